//--- hdl/clk_ctl.sv
// Idle-mode clock control and per-module clock gating
`timescale 1ns/100ps
module clk_ctl
	import clk_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	// Processor events
	input  wire logic                sleep_exec,
	input  wire logic                wake_event,
	// Always-on users of the oscillator
	input  wire logic                wdt_enable,
	input  wire logic                fscm_enable,
	// Oscillator and primary source control
	output logic                     internal_oscillator_enable,
	output logic                     primary_osc_enable,
	// Clocks
	output logic                     cpu_clk,
	output logic [NUM_MOD-1:0]       periph_clk,
	// Per-peripheral run enable (function enable and not disabled)
	output logic [NUM_MOD-1:0]       periph_run,
	// Peripheral register access, forwarded only when the module is clocked
	output periph_req_type           periph_req,
	input  wire logic [7:0]          periph_rdata
);

	osc_ctrl_type           ctrl_q;
	logic [NUM_MOD-1:0]     mod_dis_q;
	logic [NUM_MOD-1:0]     func_en_q;
	logic                   pri_run_q;
	logic                   stable_q;
	logic                   cpu_en_q;
	logic [7:0]             rdata_q;
	logic                   rd_periph_q;
	pwr_state_type          state_q;
	logic                   osc_req;
	logic                   stab_done;
	logic                   wake_done;
	logic                   on_internal_oscillator;
	logic [4:0]             p_idx;
	logic                   p_blocked;

	// Oscillator request from software fields
	function automatic logic osc_wanted(input osc_ctrl_type c);
		return (c.internal_oscillator_freq_select != 3'h0) || c.lowfreq_source_select;
	endfunction : osc_wanted

	// Address decode of one register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		return a == base;
	endfunction : hit

	assign osc_req       = osc_wanted(ctrl_q);
	assign internal_oscillator_enable = osc_req || wdt_enable || fscm_enable;

	assign on_internal_oscillator = ctrl_q.sysclk_select_upper;

	stab_timer #(
		.COUNT (CNT_W'(OSC_STAB_CYC))
	) u_stab (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.arm     (osc_req),
		.done    (stab_done)
	);

	stab_timer #(
		.COUNT (CNT_W'(WAKE_DELAY_CYC))
	) u_wake (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.arm     (state_q == ST_WAKE),
		.done    (wake_done)
	);

	// stable flag held while oscillator stays requested
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stable_q <= 1'b0;
		end else if (!osc_req) begin
			stable_q <= 1'b0;
		end else if (stab_done) begin
			stable_q <= 1'b1;
		end
	end

	// primary oscillator shut down on switch
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pri_run_q <= 1'b1;
		end else begin
			pri_run_q <= !on_internal_oscillator;
		end
	end

	assign primary_osc_enable = pri_run_q;

	// Power state machine
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_RUN;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (sleep_exec && ctrl_q.idle_on_sleep_select && on_internal_oscillator) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (wake_event) begin
						state_q <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (wake_done) begin
						state_q <= ST_RUN;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_en_q <= 1'b1;
		end else begin
			cpu_en_q <= (state_q == ST_RUN) &&
				!(sleep_exec && ctrl_q.idle_on_sleep_select && on_internal_oscillator);
		end
	end

	glitch_free_gate u_cpu_gate (
		.clk_in  (mclk),
		.enable  (cpu_en_q),
		.clk_out (cpu_clk)
	);

	// per-module gates; they ignore stabilisation and idle
	for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
		glitch_free_gate u_gate (
			.clk_in  (mclk),
			.enable  (!mod_dis_q[i]),
			.clk_out (periph_clk[i])
		);
	end

	assign periph_run = func_en_q & ~mod_dis_q;

	// Control register; wake leaves it untouched
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			// Struct is one bit short of the register; bit 3 is unimplemented
			ctrl_q <= osc_ctrl_type'(OSC_CTRL_RST[6:0]);
		end else if (reg_wr && hit(reg_addr, OSC_CTRL_ADDR)) begin
			ctrl_q.sysclk_select_lower   <= reg_wdata[SCS_LO_BIT];
			ctrl_q.sysclk_select_upper   <= reg_wdata[SCS_HI_BIT];
			ctrl_q.idle_on_sleep_select  <= reg_wdata[IDLE_SEL_BIT];
			ctrl_q.internal_oscillator_freq_select    <= reg_wdata[FREQ_MSB:FREQ_LSB];
			ctrl_q.lowfreq_source_select <= reg_wdata[LFSRC_BIT];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mod_dis_q <= {3{MOD_DIS_RST}};
		end else if (reg_wr) begin
			if (hit(reg_addr, MOD_DIS_A_ADDR)) begin
				mod_dis_q[7:0] <= reg_wdata;
			end
			if (hit(reg_addr, MOD_DIS_B_ADDR)) begin
				mod_dis_q[15:8] <= reg_wdata;
			end
			if (hit(reg_addr, MOD_DIS_C_ADDR)) begin
				mod_dis_q[23:16] <= reg_wdata;
			end
		end
	end

	// Function enables, one bit per module, indexed by the write data
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			func_en_q <= {3{MOD_EN_RST}};
		end else if (reg_wr && hit(reg_addr, MOD_EN_ADDR) && reg_wdata[4:0] < 5'd24) begin
			func_en_q[reg_wdata[4:0]] <= reg_wdata[7];
		end
	end

	// Peripheral window: address low bits select the module
	assign p_idx     = reg_addr[4:0];
	assign p_blocked = (p_idx >= 5'd24) || mod_dis_q[p_idx];

	always_comb begin
		periph_req       = '0;
		periph_req.idx   = p_idx;
		periph_req.wdata = reg_wdata;
		if (reg_addr[7:5] == PERIPH_ADDR[7:5] && !p_blocked) begin
			periph_req.wr = reg_wr;
			periph_req.rd = reg_rd;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q     <= 8'h00;
			rd_periph_q <= 1'b0;
		end else begin
			rd_periph_q <= 1'b0;
			rdata_q     <= 8'h00;
			if (reg_rd) begin
				if (hit(reg_addr, OSC_CTRL_ADDR)) begin
					rdata_q <= {ctrl_q.lowfreq_source_select, ctrl_q.internal_oscillator_freq_select,
						1'b0, ctrl_q.idle_on_sleep_select, ctrl_q.sysclk_select_upper,
						ctrl_q.sysclk_select_lower};
				end else if (hit(reg_addr, OSC_STAT_ADDR)) begin
					rdata_q <= {3'h0, internal_oscillator_enable, cpu_en_q, pri_run_q, stable_q,
						stable_q};
				end else if (hit(reg_addr, MOD_DIS_A_ADDR)) begin
					rdata_q <= mod_dis_q[7:0];
				end else if (hit(reg_addr, MOD_DIS_B_ADDR)) begin
					rdata_q <= mod_dis_q[15:8];
				end else if (hit(reg_addr, MOD_DIS_C_ADDR)) begin
					rdata_q <= mod_dis_q[23:16];
				end else if (reg_addr[7:5] == PERIPH_ADDR[7:5] && !p_blocked) begin
					rd_periph_q <= 1'b1;
				end
			end
		end
	end

	// Peripheral answers in the same cycle the read data is due
	assign reg_rdata = rd_periph_q ? periph_rdata : rdata_q;

endmodule : clk_ctl

//--- hdl/clk_ctl_pkg.sv
// Constants, types and register map for idle clock and module gating control
package clk_ctl_pkg;

	// Register offsets (byte addresses on the plain port)
	localparam logic [7:0] OSC_CTRL_ADDR   = 8'h00;
	localparam logic [7:0] OSC_STAT_ADDR   = 8'h04;
	localparam logic [7:0] MOD_DIS_A_ADDR  = 8'h08;
	localparam logic [7:0] MOD_DIS_B_ADDR  = 8'h0C;
	localparam logic [7:0] MOD_DIS_C_ADDR  = 8'h10;
	localparam logic [7:0] MOD_EN_ADDR     = 8'h14;
	localparam logic [7:0] PERIPH_ADDR     = 8'h18;

	// Control register field positions
	localparam int SCS_LO_BIT   = 0;
	localparam int SCS_HI_BIT   = 1;
	localparam int IDLE_SEL_BIT = 2;
	localparam int FREQ_LSB     = 4;
	localparam int FREQ_MSB     = 6;
	localparam int LFSRC_BIT    = 7;

	// Status register field positions
	localparam int HF_STABLE_BIT  = 0;
	localparam int MF_STABLE_BIT  = 1;
	localparam int PRI_RUN_BIT    = 2;
	localparam int CPU_RUN_BIT    = 3;
	localparam int OSC_EN_BIT     = 4;

	// Reset values
	localparam logic [7:0] OSC_CTRL_RST = 8'h00;
	localparam logic [7:0] MOD_DIS_RST  = 8'h00;
	localparam logic [7:0] MOD_EN_RST   = 8'h00;

	// Peripheral count: three disable registers of eight bits
	localparam int NUM_MOD = 24;

	// Timing, 50 MHz clock
	localparam int CLK_PERIOD_NS      = 20;
	localparam int OSC_STAB_NS        = 1000;
	localparam int OSC_STAB_CYC       = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_DELAY_NS      = 200;
	localparam int WAKE_DELAY_CYC     = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W              = 8;

	// Power state, one-hot
	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_IDLE = 3'b010,
		ST_WAKE = 3'b100
	} pwr_state_type;

	// Control fields carried together
	typedef struct packed {
		logic       lowfreq_source_select;
		logic [2:0] internal_oscillator_freq_select;
		logic       idle_on_sleep_select;
		logic       sysclk_select_upper;
		logic       sysclk_select_lower;
	} osc_ctrl_type;

	// Peripheral register access request
	typedef struct packed {
		logic [4:0] idx;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} periph_req_type;

endpackage : clk_ctl_pkg

//--- hdl/glitch_free_gate.sv
// Glitch-free clock gate: enable latched while the clock is low
`timescale 1ns/100ps
module glitch_free_gate
	import clk_ctl_pkg::*;
(
	// Clock and enable
	input  wire logic clk_in,
	input  wire logic enable,
	// Gated clock
	output logic      clk_out
);
	logic en_lat;

	// Latch transparent only while clock is low, so no runt pulse escapes
	always_latch begin
		if (!clk_in) begin
			en_lat <= enable;
		end
	end

	assign clk_out = clk_in & en_lat;

endmodule : glitch_free_gate

//--- hdl/stab_timer.sv
// Up counter that raises done after a fixed number of cycles while armed
`timescale 1ns/100ps
module stab_timer
	import clk_ctl_pkg::*;
#(
	parameter logic [CNT_W-1:0] COUNT = 8'h01
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Arm level; dropping it restarts the wait
	input  wire logic arm,
	// Wait complete
	output logic      done
);
	logic [CNT_W-1:0] cnt_q;

	// Count while armed, hold at COUNT when done
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
		end else if (!arm) begin
			cnt_q <= 8'h00;
		end else if (cnt_q != COUNT) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	assign done = arm && (cnt_q == COUNT);

endmodule : stab_timer

//--- tb/clk_ctl_asserts.sv
// Assertion checker for the idle clock and module gating block
`timescale 1ns/100ps
module clk_ctl_asserts
	import clk_ctl_pkg::*;
(
	// Clock and reset
	input wire logic               mclk,
	input wire logic               sys_rst,
	// Register port
	input wire logic [7:0]         reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [7:0]         reg_rdata,
	// Events and oscillator users
	input wire logic               sleep_exec,
	input wire logic               wake_event,
	input wire logic               wdt_enable,
	input wire logic               fscm_enable,
	// Outputs watched
	input wire logic               internal_oscillator_enable,
	input wire logic               primary_osc_enable,
	input wire logic               cpu_clk,
	input wire logic [NUM_MOD-1:0] periph_clk,
	input wire logic [NUM_MOD-1:0] periph_run,
	input wire periph_req_type     periph_req,
	input wire logic [7:0]         periph_rdata
);
	logic [7:0]         ctrl_q;
	logic [NUM_MOD-1:0] dis_q;
	logic [7:0]         on_cnt_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// Shadow of control and disable writes, so outputs can be tied to their cause
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= 8'h00;
			dis_q  <= '0;
		end else if (reg_wr) begin
			if (reg_addr == OSC_CTRL_ADDR) ctrl_q <= reg_wdata;
			if (reg_addr == MOD_DIS_A_ADDR) dis_q[7:0] <= reg_wdata;
			if (reg_addr == MOD_DIS_B_ADDR) dis_q[15:8] <= reg_wdata;
			if (reg_addr == MOD_DIS_C_ADDR) dis_q[23:16] <= reg_wdata;
		end
	end

	// Cycles the oscillator has been requested; saturates so it never wraps
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) on_cnt_q <= 8'h00;
		else if (!(|ctrl_q[7:4])) on_cnt_q <= 8'h00;
		else if (on_cnt_q != 8'hFF) on_cnt_q <= on_cnt_q + 8'h01;
	end

	osc_cause_a: assert property (internal_oscillator_enable == (|ctrl_q[7:4] || wdt_enable || fscm_enable))
		else $error("oscillator enable does not follow its requests");
	pri_osc_a: assert property ($stable(ctrl_q[1]) |-> primary_osc_enable == !ctrl_q[1])
		else $error("primary oscillator enable wrong");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	stab_early_a: assert property (reg_rd && reg_addr == OSC_STAT_ADDR && on_cnt_q < 8'h28
		|=> !reg_rdata[HF_STABLE_BIT]) else $error("stable flag set too early");
	stab_late_a: assert property (reg_rd && reg_addr == OSC_STAT_ADDR && on_cnt_q > 8'h3C
		|=> reg_rdata[1:0] == 2'h3) else $error("stable flags not set");
	gate_off_a: assert property (@(negedge mclk) disable iff (sys_rst)
		(periph_clk & dis_q & $past(dis_q)) == '0) else $error("disabled module clocked");
	gate_on_a: assert property (@(negedge mclk) disable iff (sys_rst)
		(~periph_clk & ~dis_q & ~$past(dis_q)) == '0) else $error("enabled module not clocked");
	idle_stop_a: assert property (@(negedge mclk) disable iff (sys_rst)
		sleep_exec && ctrl_q[2] && ctrl_q[1] |-> ##2 (!cpu_clk)[*3]) else $error("cpu clock runs in idle");
	wake_delay_a: assert property (@(negedge mclk) disable iff (sys_rst)
		!cpu_clk && wake_event |-> (!cpu_clk)[*8] ##1 (!cpu_clk)[*3] ##[1:4] cpu_clk)
		else $error("wake delay wrong");
	req_refuse_a: assert property (periph_req.wr |-> !dis_q[periph_req.idx] && periph_req.idx < 5'h18)
		else $error("write forwarded to disabled module");

	// Main scenarios reached
	cover property (sleep_exec && ctrl_q[2] && ctrl_q[1]);
	cover property (periph_req.wr);
	cover property (on_cnt_q == 8'h3D);
endmodule : clk_ctl_asserts

bind clk_ctl clk_ctl_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sleep_exec(sleep_exec), .wake_event(wake_event), .wdt_enable(wdt_enable),
	.fscm_enable(fscm_enable), .internal_oscillator_enable(internal_oscillator_enable),
	.primary_osc_enable(primary_osc_enable), .cpu_clk(cpu_clk), .periph_clk(periph_clk),
	.periph_run(periph_run), .periph_req(periph_req), .periph_rdata(periph_rdata));

//--- tb/testbench.sv
// Self-checking bench for the idle clock and module gating block
`timescale 1ns/100ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin err_count++; \
	$display("wrong value %s exp %h got %h", n, e, v); end end
module testbench
	import clk_ctl_pkg::*;
;
	logic               mclk;
	logic               sys_rst;
	logic [7:0]         reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_rdata;
	logic               sleep_exec;
	logic               wake_event;
	logic               wdt_enable;
	logic               fscm_enable;
	logic               internal_oscillator_enable;
	logic               primary_osc_enable;
	logic               cpu_clk;
	logic [NUM_MOD-1:0] periph_clk;
	logic [NUM_MOD-1:0] periph_run;
	periph_req_type     periph_req;
	logic [7:0]         periph_rdata;
	int                 err_count;
	int                 checked;
	int                 i;
	int                 k;
	int                 fwd_count = 0;

	clk_ctl u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
		.wake_event(wake_event), .wdt_enable(wdt_enable), .fscm_enable(fscm_enable),
		.internal_oscillator_enable(internal_oscillator_enable), .primary_osc_enable(primary_osc_enable),
		.cpu_clk(cpu_clk), .periph_clk(periph_clk), .periph_run(periph_run),
		.periph_req(periph_req), .periph_rdata(periph_rdata));

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Writes that reach peripheral five, counted at the edge that takes them
	always @(posedge mclk) begin
		if (periph_req.wr && periph_req.idx == 5'h05 && periph_req.wdata == 8'h33) begin
			fwd_count <= fwd_count + 1;
		end
	end

	// One write cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wr

	// One read cycle, data compared in the answer cycle only
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1 `CHK($sformatf("reg %h", a), e, reg_rdata)
	endtask : rchk

	// Land in the high phase, where gated clocks show whether they run
	task automatic hi;
		@(posedge mclk);
		#5;
	endtask : hi

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#60000;
		err_count++;
		report_and_stop;
	end

	initial begin
		err_count = 0;
		checked = 0;
		sys_rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{sleep_exec, wake_event, wdt_enable, fscm_enable} = 4'h0;
		periph_rdata = 8'h5A;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		rchk(OSC_CTRL_ADDR, OSC_CTRL_RST);
		rchk(OSC_STAT_ADDR, 8'h0C);
		for (k = 0; k < 3; k++) rchk(MOD_DIS_A_ADDR + 8'(4 * k), MOD_DIS_RST);
		rchk(8'h24, 8'h00);
		$display("test reset done");
		// Every frequency code, with and without the low-frequency source
		for (i = 1; i < 16; i++) begin
			wr(OSC_CTRL_ADDR, 8'(i << 4));
			#1 `CHK("osc on", 1'b1, internal_oscillator_enable)
		end
		wr(OSC_CTRL_ADDR, 8'h00);
		#1 `CHK("osc off", 1'b0, internal_oscillator_enable)
		for (k = 1; k < 3; k++) begin
			@(posedge mclk);
			{fscm_enable, wdt_enable} <= 2'(k);
			@(posedge mclk);
			#1 `CHK("osc kept", 1'b1, internal_oscillator_enable)
		end
		@(posedge mclk);
		{fscm_enable, wdt_enable} <= 2'h0;
		wr(OSC_CTRL_ADDR, 8'h70);
		repeat (20) @(posedge mclk);
		rchk(OSC_STAT_ADDR, 8'h1C);
		repeat (40) @(posedge mclk);
		rchk(OSC_STAT_ADDR, 8'h1F);
		$display("test oscillator done");
		// Idle entry with the lower select bit both clear and set
		for (k = 0; k < 2; k++) begin
			// Software order: idle-select first, then the upper select bit
			wr(OSC_CTRL_ADDR, 8'h74 | 8'(k));
			wr(OSC_CTRL_ADDR, 8'h76 | 8'(k));
			rchk(OSC_STAT_ADDR, 8'h1B);
			`CHK("primary off", 1'b0, primary_osc_enable)
			@(posedge mclk);
			sleep_exec <= 1'b1;
			@(posedge mclk);
			sleep_exec <= 1'b0;
			repeat (3) hi;
			`CHK("cpu idle", 1'b0, cpu_clk)
			`CHK("periph in idle", 1'b1, periph_clk[0])
			rchk(OSC_STAT_ADDR, 8'h13);
			@(posedge mclk);
			wake_event <= 1'b1;
			@(posedge mclk);
			wake_event <= 1'b0;
			repeat (4) hi;
			`CHK("cpu waits", 1'b0, cpu_clk)
			for (i = 0; i < 20 && cpu_clk !== 1'b1; i++) hi;
			`CHK("cpu resumes", 1'b1, cpu_clk)
			rchk(OSC_CTRL_ADDR, 8'h76 | 8'(k));
		end
		$display("test idle done");
		// Each disable register gates its own byte of clocks
		for (k = 0; k < 3; k++) begin
			wr(MOD_DIS_A_ADDR + 8'(4 * k), 8'hA5);
			rchk(MOD_DIS_A_ADDR + 8'(4 * k), 8'hA5);
			repeat (2) hi;
			`CHK("gated byte", 8'h5A, periph_clk[8 * k +: 8])
			wr(MOD_DIS_A_ADDR + 8'(4 * k), 8'h00);
		end
		wr(MOD_EN_ADDR, 8'h85);
		#1 `CHK("run on", 1'b1, periph_run[5])
		wr(8'h05, 8'h33);
		#1 `CHK("write passed", 1, fwd_count)
		wr(MOD_DIS_A_ADDR, 8'h20);
		#1 `CHK("run disabled", 1'b0, periph_run[5])
		wr(8'h05, 8'h33);
		#1 `CHK("write blocked", 1, fwd_count)
		rchk(8'h05, 8'h00);
		wr(MOD_DIS_A_ADDR, 8'h00);
		wr(MOD_EN_ADDR, 8'h05);
		#1 `CHK("run off", 1'b0, periph_run[5])
		rchk(8'h05, 8'h5A);
		$display("test module gating done");
		report_and_stop;
	end
endmodule : testbench
